// File: hdl/output_driver_enable_gate.sv
// Driver enable gating, fault status latching and local interrupt routing.
// Overview of operation
// - Low-side 1-6 need pin high, both supplies good, clock if checked.
// - Low-side 7 needs both supplies good; clock and pin checks optional.
// - High-side needs pin, supplies, optional clock and optional boost checks.
// - Seven-bit status register latches every driver-disabling error except a missing clock seen only by the low-side 7 clock check.
// - Pin history bit reads 0 once pin was low since last clear.
// - Live pin bit mirrors the enable pin, never latched.
// - Overtemperature latches but never disables drivers.
// - Core bit latches core undervoltage or ground loss; separate 5 V bit.
// - Clock-missing bit sets only when the missing clock disables drivers.
// - Error bit clears on status write only when the error is gone.
// - Status read also clears error bits when clear-on-read is enabled.
// - Local interrupt from five masked causes: pin, boost, 5 V, core, overtemperature.
// - Local interrupt forwarded to host pin and four cores, each gated.
// - Return mode 0: return request to cores when drivers re-enable.
// - Return mode 1: return request when status register is cleared.
// - Boost-disable enable makes boost undervoltage disable and latch.
// - Boost divider select: 0 divides by 32, 1 divides by 4.
// - Low-side 7 bypass ignores the enable pin.
// - Group bypass frees high-side 5, low-side 3 and 6 from the pin.
// - External core supply bit 1 disables the internal regulator.
// - Strap captured at reset release; inverse overrides during bootstrap init.
// - Serial-port reset leaves the captured strap unchanged.
module output_driver_enable_gate #(
    parameter int HS_COUNT = 5,
    parameter int LS_COUNT = 7
) (
    // Clock and resets.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_on_reset_n,
    input wire logic pin_reset_n,
    // Register port.
    input wire drv_gate_pkg::reg_req_t req,
    output logic [15:0] rdata,
    // Monitors and external configuration.
    input wire drv_gate_pkg::monitor_t mon,
    input wire drv_gate_pkg::behav_t behav,
    input wire logic trace_strap_pin,
    input wire logic bootstrap_init,
    // Driver enables.
    output logic [HS_COUNT-1:0] highside_gate_allow,
    output logic [LS_COUNT-1:0] lowside_gate_allow,
    // Interrupts and regulator control.
    output logic host_interrupt_pin,
    output logic [3:0] core_irq,
    output logic [3:0] core_iret,
    output logic boost_div_by_four,
    output logic core_regulator_off
);
    import drv_gate_pkg::*;

    // Refuse driver counts that the fixed gating terms cannot serve.
    if (HS_COUNT != 5 || LS_COUNT != 7) begin
        $error("Driver counts must be 5 high-side and 7 low-side.");
    end

    logic [15:0] cfg_r;
    logic [6:0] stat_r;
    logic strap_r;
    logic rst_seen_r;
    logic all_on_r;
    logic [HS_COUNT-1:0] hs_nxt;
    logic [LS_COUNT-1:0] ls_nxt;
    logic supplies_ok, clk_ok, boost_ok, pin, core_err;
    logic [6:0] err_now;
    logic cfg_wr, stat_wr, stat_rd, stat_clear;
    logic local_irq;

    assign pin = mon.drive_enable_pin;
    assign core_err = mon.core_supply_low | mon.ground_loss;
    assign supplies_ok = !core_err && !mon.five_volt_supply_low;
    assign clk_ok = mon.clock_present || !behav.clock_check;
    assign boost_ok = !(mon.boost_voltage_low && cfg_r[C_BOOST_DIS]);
    assign cfg_wr = req.wr && req.addr == CFG_ADDR;
    assign stat_wr = req.wr && req.addr == STAT_ADDR;
    assign stat_rd = req.rd && req.addr == STAT_ADDR;
    assign stat_clear = stat_wr || (stat_rd && behav.clear_on_read);

    always_comb begin
        for (int i = 0; i < LS_COUNT; i++) begin
            ls_nxt[i] = supplies_ok && clk_ok && pin;
        end
        // Group bypass on low-side 3 and 6.
        ls_nxt[2] = supplies_ok && clk_ok && (pin || cfg_r[C_GROUP_BYP]);
        ls_nxt[5] = supplies_ok && clk_ok && (pin || cfg_r[C_GROUP_BYP]);
        ls_nxt[6] = supplies_ok
            && (mon.clock_present || !behav.ls7_clock_check)
            && (pin || !behav.ls7_pin_check || cfg_r[C_LS7_BYP]);
        for (int i = 0; i < HS_COUNT; i++) begin
            hs_nxt[i] = supplies_ok && clk_ok && boost_ok && pin;
        end
        hs_nxt[4] = supplies_ok && clk_ok && boost_ok && (pin || cfg_r[C_GROUP_BYP]);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            highside_gate_allow <= '0;
            lowside_gate_allow <= '0;
        end else begin
            highside_gate_allow <= hs_nxt;
            lowside_gate_allow <= ls_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_r <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg_r <= req.wdata;
        end
    end

    always_comb begin
        err_now = '0;
        err_now[S_VCCP] = core_err;
        err_now[S_VCC5] = mon.five_volt_supply_low;
        err_now[S_BOOST] = mon.boost_voltage_low && cfg_r[C_BOOST_DIS];
        err_now[S_OT] = mon.over_temp;
        err_now[S_CLK] = !mon.clock_present && behav.clock_check;
    end

    // Status latching; error set wins over clear, pin low wins over history set.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stat_r <= STAT_RESET;
        end else begin
            for (int i = 0; i < STAT_BITS; i++) begin
                if (i == S_PIN_NOW) begin
                    stat_r[i] <= pin;
                end else if (i == S_PIN_HIST) begin
                    if (!pin) begin
                        stat_r[i] <= 1'b0;
                    end else if (stat_clear) begin
                        stat_r[i] <= 1'b1;
                    end
                end else if (err_now[i]) begin
                    stat_r[i] <= 1'b1;
                end else if (stat_clear) begin
                    stat_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (req.rd) begin
            if (req.addr == CFG_ADDR) begin
                rdata <= cfg_r;
            end else if (req.addr == STAT_ADDR) begin
                rdata <= {9'h000, stat_r};
            end else begin
                rdata <= '0;
            end
        end
    end

    assign local_irq = (!pin && cfg_r[C_PIN_IRQ])
        || (mon.boost_voltage_low && cfg_r[C_BOOST_IRQ])
        || (mon.five_volt_supply_low && cfg_r[C_VCC5_IRQ])
        || (core_err && cfg_r[C_VCCP_IRQ])
        || (mon.over_temp && cfg_r[C_OT_IRQ]);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            host_interrupt_pin <= 1'b0;
            core_irq <= '0;
        end else begin
            host_interrupt_pin <= local_irq && cfg_r[C_MCU];
            core_irq <= {4{local_irq}} & cfg_r[C_CORE3:C_CORE0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            all_on_r <= 1'b0;
            core_iret <= '0;
        end else begin
            all_on_r <= &{hs_nxt, ls_nxt};
            if (cfg_r[C_IRET]) begin
                core_iret <= {4{stat_clear}};
            end else begin
                core_iret <= {4{(&{hs_nxt, ls_nxt}) && !all_on_r}};
            end
        end
    end

    // Strap captured on hard reset release only.
    always_ff @(posedge mclk) begin
        if (!power_on_reset_n || !pin_reset_n) begin
            rst_seen_r <= 1'b1;
        end else begin
            rst_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_seen_r && power_on_reset_n && pin_reset_n) begin
            strap_r <= trace_strap_pin;
        end
    end

    assign boost_div_by_four = cfg_r[C_BOOST_MON];
    assign core_regulator_off = bootstrap_init ? !strap_r : cfg_r[C_VCCP_EXT];
endmodule

// File: hdl/drv_gate_pkg.sv
// Package for the output driver enable gate: register map, fields and types.
package drv_gate_pkg;
    localparam logic [9:0] CFG_ADDR = 10'h1c5;
    localparam logic [9:0] STAT_ADDR = 10'h1d2;
    localparam logic [15:0] CFG_RESET = 16'h6000;
    localparam int STAT_BITS = 7;
    // Config field positions.
    localparam int C_MCU = 0;
    localparam int C_CORE0 = 1;
    localparam int C_CORE3 = 4;
    localparam int C_IRET = 5;
    localparam int C_VCCP_IRQ = 6;
    localparam int C_VCC5_IRQ = 7;
    localparam int C_BOOST_IRQ = 8;
    localparam int C_PIN_IRQ = 9;
    localparam int C_OT_IRQ = 10;
    localparam int C_BOOST_DIS = 11;
    localparam int C_BOOST_MON = 12;
    localparam int C_LS7_BYP = 13;
    localparam int C_VCCP_EXT = 14;
    localparam int C_GROUP_BYP = 15;
    // Status field positions.
    localparam int S_VCCP = 0;
    localparam int S_VCC5 = 1;
    localparam int S_BOOST = 2;
    localparam int S_OT = 3;
    localparam int S_PIN_NOW = 4;
    localparam int S_PIN_HIST = 5;
    localparam int S_CLK = 6;
    localparam logic [6:0] STAT_RESET = 7'h21;

    typedef struct packed {
        logic clock_present;
        logic drive_enable_pin;
        logic core_supply_low;
        logic ground_loss;
        logic five_volt_supply_low;
        logic boost_voltage_low;
        logic over_temp;
    } monitor_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic ls7_clock_check;
        logic ls7_pin_check;
        logic clock_check;
        logic clear_on_read;
    } behav_t;
endpackage

// File: testbench/host_port_model.sv
// Host model that issues register writes and reads to the gate.
module host_port_model (
    // Clock and register port.
    input wire logic mclk,
    output drv_gate_pkg::reg_req_t req,
    input wire logic [15:0] rdata
);
    import drv_gate_pkg::*;
    initial req = '0;
    task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge mclk);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge mclk);
        req = '0;
        q = rdata;
    endtask
endmodule

// File: testbench/gate_properties.sv
// Concurrent checks on the driver enable gate ports.
module gate_properties #(
    parameter int HS_COUNT = 5,
    parameter int LS_COUNT = 7
) (
    // All ports of the gate.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_on_reset_n,
    input wire logic pin_reset_n,
    input wire drv_gate_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire drv_gate_pkg::monitor_t mon,
    input wire drv_gate_pkg::behav_t behav,
    input wire logic trace_strap_pin,
    input wire logic bootstrap_init,
    input wire logic [HS_COUNT-1:0] highside_gate_allow,
    input wire logic [LS_COUNT-1:0] lowside_gate_allow,
    input wire logic host_interrupt_pin,
    input wire logic [3:0] core_irq,
    input wire logic [3:0] core_iret,
    input wire logic boost_div_by_four,
    input wire logic core_regulator_off
);
    import drv_gate_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic good = !mon.core_supply_low && !mon.five_volt_supply_low;
    wire logic cause = !mon.drive_enable_pin || !good || mon.boost_voltage_low || mon.over_temp;
    a_lowside_gate: assert property (lowside_gate_allow[0] |-> $past(good &&
        mon.drive_enable_pin && (mon.clock_present || !behav.clock_check))) else $error("ls on");
    a_ls7_supply: assert property (lowside_gate_allow[LS_COUNT-1] |-> $past(good))
        else $error("ls7 on");
    a_highside_pin: assert property (highside_gate_allow[0] |->
        $past(good && mon.drive_enable_pin)) else $error("hs on");
    a_read_upper: assert property ($past(req.rd) && $past(req.addr) == STAT_ADDR |->
        rdata[15:7] == 9'h0) else $error("status upper");
    a_irq_cause: assert property (host_interrupt_pin |->
        $past(cause) || $past(cause, 2)) else $error("irq no cause");
    a_iret_pulse: assert property (core_iret != 4'h0 |->
        core_iret == 4'hf ##1 core_iret == 4'h0) else $error("iret shape");
    a_strap_kept: assert property (disable iff (!power_on_reset_n)
        bootstrap_init && $past(bootstrap_init) && $past(pin_reset_n) && $past(power_on_reset_n)
        && $past(pin_reset_n, 2) && $past(power_on_reset_n, 2)
        |-> $stable(core_regulator_off)) else $error("strap moved");
    a_div_stable: assert property (!$past(req.wr && req.addr == CFG_ADDR) |->
        $stable(boost_div_by_four)) else $error("divider moved");
endmodule
bind output_driver_enable_gate gate_properties #(.HS_COUNT(HS_COUNT), .LS_COUNT(LS_COUNT)) chk (
    .mclk, .rst_n, .power_on_reset_n, .pin_reset_n, .req, .rdata, .mon, .behav,
    .trace_strap_pin, .bootstrap_init, .highside_gate_allow, .lowside_gate_allow,
    .host_interrupt_pin, .core_irq, .core_iret, .boost_div_by_four, .core_regulator_off);

// File: testbench/tb.sv
// Self-checking testbench for the output driver enable gate.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import drv_gate_pkg::*;
    logic mclk, rst_n, por_n, prst_n, strap, boot, irq, div4, roff;
    monitor_t mon;
    behav_t behav;
    reg_req_t req;
    logic [15:0] rdata, q;
    logic [4:0] hs;
    logic [6:0] ls;
    logic [3:0] cirq, iret;
    int miscompares = 0, check_count = 0, iret_seen = 0, n;
    host_port_model host (.mclk(mclk), .req(req), .rdata(rdata));
    output_driver_enable_gate dut (.mclk(mclk), .rst_n(rst_n), .power_on_reset_n(por_n),
        .pin_reset_n(prst_n), .req(req), .rdata(rdata), .mon(mon), .behav(behav),
        .trace_strap_pin(strap), .bootstrap_init(boot), .highside_gate_allow(hs),
        .lowside_gate_allow(ls), .host_interrupt_pin(irq), .core_irq(cirq),
        .core_iret(iret), .boost_div_by_four(div4), .core_regulator_off(roff));
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) if (iret === 4'hf) iret_seen++;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d); host.xfer(1, a, d, q); endtask
    task automatic rd(input logic [9:0] a); host.xfer(0, a, 16'h0, q); endtask
    task automatic settle; repeat (2) @(negedge mclk); endtask
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
    initial begin
        {rst_n, por_n, prst_n, strap, boot} = 5'h01;
        behav = 4'he;
        mon = '0;
        {mon.clock_present, mon.drive_enable_pin} = 2'h3;
        repeat (3) @(negedge mclk);
        {rst_n, por_n, prst_n} = 3'h7;
        rd(CFG_ADDR); `CHK(q, CFG_RESET)
        rd(STAT_ADDR); `CHK(q, 16'h0031)
        `CHK(roff, 1'b1)
        rst_n = 0; strap = 1; settle; rst_n = 1; settle;
        `CHK(roff, 1'b1)
        boot = 0; wr(CFG_ADDR, 16'h17df); rd(CFG_ADDR); `CHK(q, 16'h17df)
        `CHK({roff, div4}, 2'h1)
        $display("test reset done");
        wr(STAT_ADDR, 16'h0); rd(STAT_ADDR); `CHK(q, 16'h0030)
        `CHK({hs, ls, irq}, 13'h1ffe)
        mon.drive_enable_pin = 0; settle;
        `CHK({hs, ls, irq, cirq}, 17'h0001f)
        rd(STAT_ADDR); `CHK(q, 16'h0000)
        n = iret_seen; mon.drive_enable_pin = 1; settle;
        `CHK(iret_seen, n + 1)
        rd(STAT_ADDR); `CHK(q, 16'h0010)
        wr(CFG_ADDR, 16'ha000); mon.drive_enable_pin = 0; settle;
        `CHK({hs, ls}, 12'h864)
        mon.drive_enable_pin = 1; mon.clock_present = 0; settle; `CHK(ls, 7'h0)
        rd(STAT_ADDR); `CHK(q[6], 1'b1)
        $display("test pin done");
        mon.clock_present = 1; mon.five_volt_supply_low = 1; settle;
        `CHK({hs, ls}, 12'h0)
        wr(STAT_ADDR, 16'h0); rd(STAT_ADDR); `CHK(q[1], 1'b1)
        mon.five_volt_supply_low = 0; wr(STAT_ADDR, 16'h0); rd(STAT_ADDR);
        `CHK(q[1], 1'b0)
        wr(CFG_ADDR, 16'h0800); mon.boost_voltage_low = 1; settle;
        `CHK({hs, ls}, 12'h07f)
        mon.boost_voltage_low = 0; mon.over_temp = 1; settle;
        `CHK({hs, ls}, 12'hfff)
        rd(STAT_ADDR); `CHK(q[3:2], 2'h3)
        mon.over_temp = 0; mon.ground_loss = 1; settle;
        `CHK({hs, ls}, 12'h0)
        rd(STAT_ADDR); `CHK(q[0], 1'b1)
        mon.ground_loss = 0; mon.over_temp = 1; settle;
        $display("test faults done");
        wr(CFG_ADDR, 16'h0020); behav.clear_on_read = 1; mon.over_temp = 0; n = iret_seen;
        rd(STAT_ADDR); rd(STAT_ADDR); `CHK(q[3:0], 4'h0)
        `CHK(iret_seen != n, 1'b1)
        $display("test clear done");
        end_sim;
    end
endmodule
